/* tws_cfg.svh */
// Constants of the three-wire control slave: codes, field positions, reset values.
// Assumes inclusion by bare name from design files that also use tws_pkg.
// Functional notes
// - Addressing phase: mode low, eight clocked bits.
// - Address byte: two mode bits, six address bits.
// - Direction stays fixed within one data phase.
// - Mode bits pick write, read, control, status.
// - All-zero address is special, never normal.
// - Data phase: mode high, eight bits per byte.
// - LSB first, bit stable during clock low.
// - Bytes; sixteen-bit units as two bytes, MSB first.
// - Pause between units: mode low, clock high.
// - Bit counter works with or without pauses.
// - Special address, mode 00: nobody drives data.
// - Valid own address restores communication after reset.
// - Fixed-address slave resets on any special address.
// - Programmable slave resets only on modes 00 and 11.
// - Declaration: special 01, identification code, address byte.
// - Identification byte bit 0 means more follow.
// - Invalidation: special 10, code, then stay reset.
// - Special address with mode 11 acts as reset.
// - All slaves decode, only addressed one takes part.
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
`define TWS_BYTE_BITS 8
`define TWS_OA_LSB 2
`define TWS_OA_MSB 7
`define TWS_DOM_LSB 0
`define TWS_DOM_MSB 1
`define TWS_OA_SPECIAL 6'h00
`define TWS_DOM_WRITE 2'h0
`define TWS_DOM_READ 2'h1
`define TWS_DOM_CONTROL 2'h2
`define TWS_DOM_STATUS 2'h3
`define TWS_ID_CONT_BIT 0
`define TWS_PREF_OA_LO 6'h38
`define TWS_PREF_OA_HI 6'h3f
`define TWS_OA_RESET 6'h00
`define TWS_BYTE_RESET 8'h00
`define TWS_CLK_PERIOD_NS 100
`endif

/* tws_pkg.sv */
// Types shared by the three-wire control slave modules.
// Assumes tws_cfg.svh holds the numeric constants.
package tws_pkg;
    typedef logic [1:0] tws_dom_t;
    typedef logic [5:0] tws_oa_t;
    typedef logic [7:0] tws_byte_t;
    typedef enum logic [5:0] {
        TWS_ST_IDLE = 6'h01,
        TWS_ST_DATA = 6'h02,
        TWS_ST_DECL_ID = 6'h04,
        TWS_ST_DECL_ADDR = 6'h08,
        TWS_ST_INV_ID = 6'h10,
        TWS_ST_MUTE = 6'h20
    } tws_state_e;
endpackage

/* tws_link_if.sv */
// Carrier between the bit-clock front end and the core of the control slave.
// Assumes rx_byte and rx_tag stay stable between two toggles of rx_tgl.
`timescale 1ns/100ps
interface tws_link_if;
    tws_pkg::tws_byte_t rx_byte;
    logic rx_tag;
    logic rx_tgl;
    tws_pkg::tws_byte_t tx_word;
    modport link (
        output rx_byte,
        output rx_tag,
        output rx_tgl,
        input tx_word
    );
    modport core (
        input rx_byte,
        input rx_tag,
        input rx_tgl,
        output tx_word
    );
endinterface

/* tws_link.sv */
// Bit-clock front end: shifts bytes in and out on the host's bit clock.
// Assumes the host changes mode only while the bit clock is high.
`timescale 1ns/100ps
`include "tws_cfg.svh"
module tws_link (
    input wire logic bus_bit_clock,
    input wire logic rst_n,
    input wire logic bus_phase_select,
    input wire logic bus_serial_data_in,
    output logic data_out,
    tws_link_if.link lk
);
    logic mode_prev_q;
    logic [2:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] byte_q;
    logic tag_q;
    logic tgl_q;
    logic rd_mode_prev_q;
    logic [2:0] rd_cnt_q;
    logic [7:0] shadow_q;
    logic out_q;
    logic [2:0] idx;
    logic [2:0] ridx;
    logic [7:0] shift_d;

    // A mode change seen at a clock edge restarts the bit count, so pauses are optional
    assign idx = (bus_phase_select != mode_prev_q) ? 3'h0 : cnt_q;
    assign ridx = (bus_phase_select != rd_mode_prev_q) ? 3'h0 : rd_cnt_q;
    assign shift_d = {bus_serial_data_in, shift_q[7:1]};

    // Link clock stops between frames, so its flops reset without it
    always_ff @(posedge bus_bit_clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_prev_q <= 1'b1;
            cnt_q <= 3'h0;
            shift_q <= `TWS_BYTE_RESET;
        end else begin
            mode_prev_q <= bus_phase_select;
            shift_q <= shift_d;
            cnt_q <= (idx == 3'h7) ? 3'h0 : idx + 3'h1;
        end
    end

    always_ff @(posedge bus_bit_clock or negedge rst_n) begin
        if (!rst_n) begin
            byte_q <= `TWS_BYTE_RESET;
            tag_q <= 1'b0;
            tgl_q <= 1'b0;
        end else if (idx == 3'h7) begin
            byte_q <= shift_d;
            tag_q <= bus_phase_select;
            tgl_q <= ~tgl_q;
        end
    end

    // Bit 0 of each byte comes straight from the core word; the rest from a shadow copy
    always_ff @(negedge bus_bit_clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_mode_prev_q <= 1'b1;
            rd_cnt_q <= 3'h0;
            shadow_q <= `TWS_BYTE_RESET;
            out_q <= 1'b0;
        end else begin
            rd_mode_prev_q <= bus_phase_select;
            rd_cnt_q <= (ridx == 3'h7) ? 3'h0 : ridx + 3'h1;
            if (ridx == 3'h0) begin
                shadow_q <= lk.tx_word;
                out_q <= lk.tx_word[0];
            end else begin
                out_q <= shadow_q[ridx];
            end
        end
    end

    assign lk.rx_byte = byte_q;
    assign lk.rx_tag = tag_q;
    assign lk.rx_tgl = tgl_q;
    assign data_out = out_q;
endmodule

/* tws_slave.sv */
// Three-wire control slave: address decode, data phases, interface reset, extended addressing.
// Assumes the bit-clock pins come straight from the host and bytes are spaced well beyond
// four system clocks, since each byte crosses by a toggle.
`timescale 1ns/100ps
`include "tws_cfg.svh"
module tws_slave #(
    parameter logic PROGRAMMABLE = 1'b1,
    parameter logic [5:0] FIXED_ADDR = 6'h10,
    parameter int ID_MAX = 2,
    // Arbitrary identification code, low byte sent first
    parameter logic [ID_MAX*8-1:0] ID_CODE = 16'h4281
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic bus_bit_clock,
    input wire logic bus_phase_select,
    input wire logic bus_serial_data_in,
    output logic bus_serial_data_out,
    output logic bus_serial_data_oe,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_is_control,
    input wire logic [7:0] tx_data,
    output logic tx_load,
    output logic selected,
    output logic [1:0] op_mode,
    output logic iface_reset,
    output logic addr_valid,
    output logic [5:0] assigned_addr
);
    localparam int IDW = (ID_MAX > 1) ? $clog2(ID_MAX) : 1;

    tws_link_if lk();

    tws_pkg::tws_state_e st_q;
    tws_pkg::tws_dom_t op_q;
    logic [IDW-1:0] id_idx_q;
    logic mode_s1_q;
    logic mode_s2_q;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic addr_valid_q;
    tws_pkg::tws_oa_t addr_q;
    logic iface_rst_q;
    tws_pkg::tws_byte_t rx_data_q;
    logic rx_valid_q;
    logic rx_ctrl_q;
    tws_pkg::tws_byte_t tx_word_q;
    logic tx_load_q;
    logic byte_evt;
    logic is_addr;
    logic is_data;
    tws_pkg::tws_oa_t rx_oa;
    tws_pkg::tws_dom_t rx_dom;
    logic special;
    logic own_match;
    logic reset_hit;
    logic id_ok;
    logic id_last;
    logic read_act;
    logic read_byte;
    logic write_byte;

    function automatic logic id_match(input logic [7:0] b, input logic [IDW-1:0] i);
        logic [7:0] ref_b;
        ref_b = ID_CODE[i*8 +: 8];
        return b == ref_b;
    endfunction

    tws_link u_link (
        .bus_bit_clock(bus_bit_clock),
        .rst_n(rst_n),
        .bus_phase_select(bus_phase_select),
        .bus_serial_data_in(bus_serial_data_in),
        .data_out(bus_serial_data_out),
        .lk(lk)
    );

    // Byte events cross by toggle; mode crosses as a level
    // With ce low a pending byte waits; a second byte in that time cancels the toggle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else if (ce) begin
            mode_s1_q <= bus_phase_select;
            mode_s2_q <= mode_s1_q;
            tgl_s1_q <= lk.rx_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    assign byte_evt = ce & (tgl_s2_q ^ tgl_s3_q);
    assign is_addr = byte_evt & ~lk.rx_tag;
    assign is_data = byte_evt & lk.rx_tag;
    assign rx_oa = lk.rx_byte[`TWS_OA_MSB:`TWS_OA_LSB];
    assign rx_dom = lk.rx_byte[`TWS_DOM_MSB:`TWS_DOM_LSB];
    assign special = rx_oa == `TWS_OA_SPECIAL;
    assign own_match = !special && (PROGRAMMABLE ? (addr_valid_q && rx_oa == addr_q) : (rx_oa == FIXED_ADDR));
    // Fixed slaves reset on every special code; programmable ones on 00 and reserved 11
    assign reset_hit = special && (!PROGRAMMABLE || rx_dom == `TWS_DOM_WRITE
        || rx_dom == `TWS_DOM_STATUS);
    assign id_ok = id_match(lk.rx_byte, id_idx_q);
    assign id_last = !lk.rx_byte[`TWS_ID_CONT_BIT];
    assign read_act = (st_q == tws_pkg::TWS_ST_DATA) && op_q[0];
    assign read_byte = is_data && read_act;
    assign write_byte = is_data && (st_q == tws_pkg::TWS_ST_DATA) && !op_q[0];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= tws_pkg::TWS_ST_IDLE;
            op_q <= `TWS_DOM_WRITE;
            id_idx_q <= '0;
        end else if (is_addr) begin
            id_idx_q <= '0;
            op_q <= rx_dom;
            if (reset_hit) begin
                st_q <= tws_pkg::TWS_ST_MUTE;
            end else if (special && rx_dom == `TWS_DOM_READ) begin
                st_q <= tws_pkg::TWS_ST_DECL_ID;
            end else if (special) begin
                st_q <= tws_pkg::TWS_ST_INV_ID;
            end else if (own_match) begin
                st_q <= tws_pkg::TWS_ST_DATA;
            end else begin
                st_q <= tws_pkg::TWS_ST_IDLE;
            end
        end else if (is_data) begin
            case (st_q)
                tws_pkg::TWS_ST_DECL_ID: begin
                    if (!id_ok) begin
                        st_q <= tws_pkg::TWS_ST_IDLE;
                    end else if (id_last) begin
                        st_q <= tws_pkg::TWS_ST_DECL_ADDR;
                    end else begin
                        id_idx_q <= id_idx_q + 1'b1;
                    end
                end
                tws_pkg::TWS_ST_DECL_ADDR: begin
                    st_q <= tws_pkg::TWS_ST_IDLE;
                end
                tws_pkg::TWS_ST_INV_ID: begin
                    if (!id_ok || id_last) begin
                        st_q <= tws_pkg::TWS_ST_IDLE;
                    end else begin
                        id_idx_q <= id_idx_q + 1'b1;
                    end
                end
                default: begin
                    st_q <= st_q;
                end
            endcase
        end
    end

    // Address slot; the mode bit positions of the declared byte are ignored
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_valid_q <= 1'b0;
            addr_q <= `TWS_OA_RESET;
        end else if (is_data && st_q == tws_pkg::TWS_ST_DECL_ADDR) begin
            addr_valid_q <= 1'b1;
            addr_q <= rx_oa;
        end else if (is_data && st_q == tws_pkg::TWS_ST_INV_ID && id_ok && id_last) begin
            addr_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            iface_rst_q <= 1'b0;
        end else if (is_addr && reset_hit) begin
            iface_rst_q <= 1'b1;
        end else if (is_addr && own_match) begin
            iface_rst_q <= 1'b0;
        end else if (is_data && st_q == tws_pkg::TWS_ST_INV_ID && id_ok && id_last) begin
            iface_rst_q <= 1'b1;
        end else if (is_data && st_q == tws_pkg::TWS_ST_DECL_ADDR) begin
            iface_rst_q <= 1'b0;
        end
    end

    // Sixteen-bit units pass as two byte strobes, the first being the upper byte
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_data_q <= `TWS_BYTE_RESET;
            rx_valid_q <= 1'b0;
            rx_ctrl_q <= 1'b0;
        end else if (ce) begin
            rx_valid_q <= write_byte;
            if (write_byte) begin
                rx_data_q <= lk.rx_byte;
                rx_ctrl_q <= op_q[1];
            end
        end
    end

    // Next read byte is fetched right after the previous one is shifted out
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_word_q <= `TWS_BYTE_RESET;
            tx_load_q <= 1'b0;
        end else if (ce) begin
            tx_load_q <= (is_addr && own_match && rx_dom[0]) || read_byte;
            if ((is_addr && own_match && rx_dom[0]) || read_byte) begin
                tx_word_q <= tx_data;
            end
        end
    end

    assign lk.tx_word = tx_word_q;
    // Pin released as soon as mode falls; costs two clocks of sync latency
    assign bus_serial_data_oe = read_act && mode_s2_q;
    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign rx_is_control = rx_ctrl_q;
    assign tx_load = tx_load_q;
    assign selected = st_q == tws_pkg::TWS_ST_DATA;
    assign op_mode = op_q;
    assign iface_reset = iface_rst_q;
    assign addr_valid = addr_valid_q;
    assign assigned_addr = addr_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_decl_open;
        is_addr && special && rx_dom == `TWS_DOM_READ && PROGRAMMABLE;
    endsequence

    sequence s_decl_finish;
        is_data && st_q == tws_pkg::TWS_ST_DECL_ADDR;
    endsequence

    property p_decl_open;
        s_decl_open |=> st_q == tws_pkg::TWS_ST_DECL_ID && id_idx_q == '0;
    endproperty
    a_decl_open: assert property (p_decl_open) else $error("declaration not opened");

    property p_decl_finish;
        s_decl_finish |=> addr_valid_q && addr_q == $past(rx_oa) && !iface_rst_q
            && st_q == tws_pkg::TWS_ST_IDLE;
    endproperty
    a_decl_finish: assert property (p_decl_finish) else $error("address not stored");

    property p_reset_hit;
        is_addr && reset_hit |=> st_q == tws_pkg::TWS_ST_MUTE && iface_rst_q;
    endproperty
    a_reset_hit: assert property (p_reset_hit) else $error("special address did not reset");

    // A new address may leave mute at once and start a read, so that cycle is exempt
    property p_mute_quiet;
        st_q == tws_pkg::TWS_ST_MUTE && !is_addr |-> !bus_serial_data_oe
            ##1 !tx_load_q && !rx_valid_q;
    endproperty
    a_mute_quiet: assert property (p_mute_quiet) else $error("muted slave took part");

    property p_own_match;
        is_addr && own_match |=> st_q == tws_pkg::TWS_ST_DATA && !iface_rst_q && op_q == $past(rx_dom);
    endproperty
    a_own_match: assert property (p_own_match) else $error("own address not selected");

    property p_foreign;
        is_addr && !special && !own_match |=> st_q == tws_pkg::TWS_ST_IDLE && !bus_serial_data_oe;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address selected");

    property p_oe_dir;
        bus_serial_data_oe |-> st_q == tws_pkg::TWS_ST_DATA && op_q[0];
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("drive outside read phase");

    property p_rx_write;
        write_byte |=> rx_valid_q && rx_data_q == $past(lk.rx_byte) && rx_ctrl_q == op_q[1] ##1 !rx_valid_q || $past(write_byte);
    endproperty
    a_rx_write: assert property (p_rx_write) else $error("write byte not delivered");

    property p_id_cont;
        is_data && st_q == tws_pkg::TWS_ST_DECL_ID && id_ok && !id_last |=>
            st_q == tws_pkg::TWS_ST_DECL_ID && id_idx_q == $past(id_idx_q) + 1'b1;
    endproperty
    a_id_cont: assert property (p_id_cont) else $error("continuation not followed");

    property p_invalidate;
        is_data && st_q == tws_pkg::TWS_ST_INV_ID && id_ok && id_last |=> !addr_valid_q && iface_rst_q;
    endproperty
    a_invalidate: assert property (p_invalidate) else $error("address not invalidated");

    property p_read_fetch;
        read_byte |=> tx_load_q && tx_word_q == $past(tx_data);
    endproperty
    a_read_fetch: assert property (p_read_fetch) else $error("next read byte not fetched");
endmodule

/* tws_host.sv */
// Host model for the three-wire control bus: drives mode, bit clock and data.
// Assumes the bench resolves the data wire from every party's enable.
`timescale 1ns/100ps
module tws_host (
    output logic bus_bit_clock,
    output logic bus_phase_select,
    output logic host_d,
    output logic host_drv,
    input wire logic line
);
    // Bit clock stands high outside frames; gaps keep bytes well apart for the core's sync
    initial begin
        bus_bit_clock = 1'b1;
        bus_phase_select = 1'b1;
        host_d = 1'b0;
        host_drv = 1'b0;
    end
    task automatic put_byte(input logic [7:0] b);
        // Data moves inside the high phase, never at the rising edge the slave samples
        for (int i = 0; i < 8; i++) begin
            #3 host_d = b[i];
            host_drv = 1'b1;
            #3 bus_bit_clock = 1'b0;
            #6 bus_bit_clock = 1'b1;
        end
        #2 host_drv = 1'b0;
        #700;
    endtask
    task automatic address(input logic [7:0] b);
        bus_phase_select = 1'b0;
        #300;
        put_byte(b);
        bus_phase_select = 1'b1;
        #300;
    endtask
    task automatic get_byte(output logic [7:0] b);
        #800;
        for (int i = 0; i < 8; i++) begin
            bus_bit_clock = 1'b0;
            #6 b[i] = line;
            bus_bit_clock = 1'b1;
            #6;
        end
        #700;
    endtask
    task automatic pause();
        bus_phase_select = 1'b0;
        #400;
        bus_phase_select = 1'b1;
        #400;
    endtask
endmodule

/* tb_three_wire_control_slave.sv */
// Testbench of the three-wire control slave: a programmable and a fixed slave share one bus.
// Assumes tws_host drives the bus side; the data wire is resolved here.
`timescale 1ns/100ps
module tb_three_wire_control_slave;
    logic clock;
    logic rst_n;
    logic ce;
    logic [7:0] tx_data;
    logic bus_bit_clock, bus_phase_select, host_d, host_drv, bus_line;
    logic p_out, p_oe, p_rxv, p_rxc, p_txl, p_sel, p_irst, p_av;
    logic f_out, f_oe, f_rxv, f_rxc, f_txl, f_sel, f_irst, f_av;
    logic [7:0] p_rxd, f_rxd, b;
    logic [1:0] p_mode, f_mode;
    logic [5:0] p_aa, f_aa;
    logic [8:0] p_q[$];
    logic [8:0] f_q[$];
    logic p_oe_seen = 1'b0;
    logic f_oe_seen = 1'b0;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #50 clock = ~clock;
    // Released wire shows the inverse of the last host bit, so a stale value never passes
    assign bus_line = p_oe ? p_out : (f_oe ? f_out : (host_drv ? host_d : ~host_d));
    tws_host i_host (.bus_bit_clock(bus_bit_clock), .bus_phase_select(bus_phase_select), .host_d(host_d),
        .host_drv(host_drv), .line(bus_line));
    tws_slave i_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .bus_bit_clock(bus_bit_clock),
        .bus_phase_select(bus_phase_select), .bus_serial_data_in(bus_line), .bus_serial_data_out(p_out),
        .bus_serial_data_oe(p_oe), .rx_data(p_rxd), .rx_valid(p_rxv), .rx_is_control(p_rxc), .tx_data(tx_data),
        .tx_load(p_txl), .selected(p_sel), .op_mode(p_mode), .iface_reset(p_irst), .addr_valid(p_av),
        .assigned_addr(p_aa));
    tws_slave #(.PROGRAMMABLE(1'b0)) i_fix (.clock(clock), .rst_n(rst_n), .ce(ce), .bus_bit_clock(bus_bit_clock),
        .bus_phase_select(bus_phase_select), .bus_serial_data_in(bus_line), .bus_serial_data_out(f_out),
        .bus_serial_data_oe(f_oe), .rx_data(f_rxd), .rx_valid(f_rxv), .rx_is_control(f_rxc), .tx_data(tx_data),
        .tx_load(f_txl), .selected(f_sel), .op_mode(f_mode), .iface_reset(f_irst), .addr_valid(f_av),
        .assigned_addr(f_aa));
    always @(posedge clock) begin
        cycles++;
        if (p_rxv === 1'b1) p_q.push_back({p_rxc, p_rxd});
        if (f_rxv === 1'b1) f_q.push_back({f_rxc, f_rxd});
        if (p_oe === 1'b1) p_oe_seen = 1'b1;
        if (f_oe === 1'b1) f_oe_seen = 1'b1;
        if (cycles == 30000) begin
            fail_count++;
            $display("Error timeout expected below 30000 seen %0d", cycles);
            complete_run();
        end
    end
    // Next read byte differs from the last, so a missed load shows
    always @(posedge clock) begin
        if (p_txl === 1'b1) begin
            #1 tx_data = ~tx_data;
        end
    end
    task automatic check(input string name, input logic [8:0] exp, input logic [8:0] seen);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [8:0] pop_p();
        return (p_q.size() > 0) ? p_q.pop_front() : 9'h1ff;
    endfunction
    function automatic logic [8:0] pop_f();
        return (f_q.size() > 0) ? f_q.pop_front() : 9'h1ff;
    endfunction
    task automatic test_reset();
        repeat (4) @(posedge clock);
        #1;
        check("p_av", 9'h000, p_av);
        check("p_irst", 9'h000, p_irst);
        check("p_sel", 9'h000, p_sel);
        check("oe", 9'h000, {p_oe, f_oe});
        $display("Test reset done");
    endtask
    task automatic test_fixed_write();
        i_host.address({6'h10, 2'h0});
        i_host.put_byte(8'ha5);
        i_host.pause();
        i_host.put_byte(8'h12);
        i_host.put_byte(8'h34);
        check("f_rx0", 9'h0a5, pop_f());
        check("f_rx1", 9'h012, pop_f());
        check("f_rx2", 9'h034, pop_f());
        check("p_rx_none", 9'h000, 9'(p_q.size()));
        check("oe_idle", 9'h000, {p_oe_seen, f_oe_seen});
        $display("Test fixed write done");
    endtask
    task automatic test_declare();
        i_host.address(8'h01);
        i_host.put_byte(8'h81);
        i_host.put_byte(8'h42);
        i_host.put_byte({6'h38, 2'h3});
        check("p_av", 9'h001, p_av);
        check("p_aa", 9'h038, p_aa);
        check("f_irst", 9'h001, f_irst);
        check("f_av_aa", 9'h000, {f_av, f_aa});
        check("rx_none", 9'h000, 9'(p_q.size() + f_q.size()));
        $display("Test declare done");
    endtask
    task automatic test_control_restore();
        i_host.address({6'h38, 2'h2});
        check("p_mode", 9'h002, p_mode);
        i_host.put_byte(8'h5a);
        check("p_ctrl", 9'h15a, pop_p());
        i_host.address({6'h10, 2'h0});
        check("f_sel_mode", 9'h004, {f_sel, f_mode});
        i_host.put_byte(8'h77);
        check("f_rx", 9'h077, pop_f());
        check("f_irst", 9'h000, f_irst);
        i_host.address({6'h38, 2'h0});
        i_host.put_byte(8'h66);
        check("p_data", 9'h066, pop_p());
        $display("Test control and restore done");
    endtask
    task automatic test_read();
        @(posedge clock);
        #1 tx_data = 8'h96;
        p_oe_seen = 1'b0;
        f_oe_seen = 1'b0;
        i_host.address({6'h38, 2'h1});
        i_host.get_byte(b);
        check("rd0", 9'h096, b);
        i_host.get_byte(b);
        check("rd1", 9'h069, b);
        i_host.pause();
        i_host.get_byte(b);
        check("rd2", 9'h096, b);
        check("oe_seen", 9'h002, {p_oe_seen, f_oe_seen});
        @(posedge clock);
        #1 tx_data = 8'h3c;
        i_host.address({6'h38, 2'h3});
        i_host.get_byte(b);
        check("status", 9'h03c, b);
        check("rx_none", 9'h000, 9'(p_q.size()));
        $display("Test read done");
    endtask
    task automatic test_iface_reset();
        i_host.address(8'h00);
        p_oe_seen = 1'b0;
        f_oe_seen = 1'b0;
        i_host.put_byte(8'hff);
        check("p_oe", 9'h000, p_oe);
        check("p_irst", 9'h001, p_irst);
        check("oe_seen", 9'h000, {p_oe_seen, f_oe_seen});
        check("f_txl_sel", 9'h000, {f_txl, f_sel});
        check("rx_none", 9'h000, 9'(p_q.size() + f_q.size()));
        i_host.address({6'h38, 2'h0});
        i_host.put_byte(8'h21);
        check("p_rx", 9'h021, pop_p());
        check("p_irst", 9'h000, p_irst);
        $display("Test interface reset done");
    endtask
    // One byte lands while ce is low; it must wait, then arrive once ce returns
    task automatic test_clock_enable();
        @(posedge clock);
        #1 ce = 1'b0;
        i_host.put_byte(8'h44);
        check("ce_frozen", 9'h000, {p_rxv, 8'(p_q.size())});
        @(posedge clock);
        #1 ce = 1'b1;
        repeat (6) @(posedge clock);
        check("ce_resume", 9'h044, pop_p());
        $display("Test clock enable done");
    endtask
    task automatic test_reserved_invalidate();
        i_host.address(8'h03);
        check("p_irst", 9'h001, p_irst);
        i_host.address({6'h38, 2'h0});
        i_host.put_byte(8'h22);
        check("p_rx", 9'h022, pop_p());
        i_host.address(8'h02);
        i_host.put_byte(8'h81);
        i_host.put_byte(8'h42);
        check("p_av", 9'h000, p_av);
        check("p_irst", 9'h001, p_irst);
        i_host.address({6'h38, 2'h0});
        i_host.put_byte(8'h23);
        check("p_rx_none", 9'h000, 9'(p_q.size()));
        $display("Test reserved and invalidate done");
    endtask
    task automatic complete_run();
        $display("Counts: compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        tx_data = 8'h96;
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        test_reset();
        test_fixed_write();
        test_declare();
        test_control_restore();
        test_read();
        test_iface_reset();
        test_clock_enable();
        test_reserved_invalidate();
        complete_run();
    end
endmodule
